// *** core/rcg_pkg.sv ***
// Shared constants, types and register map of the receiver clock and supply control block
package rcg_pkg;

  // ----------------------------------------------------------------
  // Register bus shape
  // ----------------------------------------------------------------
  localparam int RCG_ADDR_W = 4;
  localparam int RCG_DATA_W = 8;
  localparam int RCG_NREGS = 13;

  typedef struct packed {
    logic we;
    logic re;
    logic [RCG_ADDR_W-1:0] addr;
    logic [RCG_DATA_W-1:0] wdata;
  } rcg_bus_req_t;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] RCG_OFS_CTRL = 4'h0;
  localparam logic [3:0] RCG_OFS_CFG_A = 4'h1;
  localparam logic [3:0] RCG_OFS_CFG_B = 4'h2;
  localparam logic [3:0] RCG_OFS_CAR_H = 4'h3;
  localparam logic [3:0] RCG_OFS_CAR_L = 4'h4;
  localparam logic [3:0] RCG_OFS_DEV = 4'h5;
  localparam logic [3:0] RCG_OFS_DLO_H = 4'h6;
  localparam logic [3:0] RCG_OFS_DLO_L = 4'h7;
  localparam logic [3:0] RCG_OFS_DCT_H = 4'h8;
  localparam logic [3:0] RCG_OFS_DCT_L = 4'h9;
  localparam logic [3:0] RCG_OFS_DHI_H = 4'ha;
  localparam logic [3:0] RCG_OFS_DHI_L = 4'hb;
  localparam logic [3:0] RCG_OFS_WAKE = 4'hc;
  localparam logic [3:0] RCG_OFS_STATUS = 4'hd;
  localparam logic [3:0] RCG_OFS_SWITCH = 4'he;

  // Control register bit positions
  localparam int RCG_CTRL_LVD_EN = 0;
  localparam int RCG_CTRL_DM_EN = 1;
  localparam int RCG_CTRL_SOSC_EN = 2;
  localparam int RCG_CTRL_AUTO_SW = 3;
  localparam int RCG_CTRL_FRIENDLY = 4;
  localparam int RCG_CTRL_RX_EN = 5;
  localparam int RCG_CTRL_LNA_LSB = 6;

  // Reset values
  localparam logic [7:0] RCG_RST_REG = 8'h00;
  localparam logic [4:0] RCG_RST_SYNC = 5'h10;
  localparam logic [11:0] RCG_RST_CNT = 12'h000;

  // ----------------------------------------------------------------
  // Bank configuration and band codes
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] lpf_bw;
    logic [1:0] rate;
    logic [1:0] lo_fine_select;
    logic [1:0] band_select;
  } rcg_cfg_t;

  localparam logic [1:0] RCG_BAND_300 = 2'h0;
  localparam logic [1:0] RCG_BAND_430 = 2'h1;
  localparam logic [1:0] RCG_BAND_900 = 2'h3;

  // Divide ratios from the crystal reference
  localparam logic [6:0] RCG_DOUT_DIV_LOW = 7'h3c;
  localparam logic [6:0] RCG_DOUT_DIV_HIGH = 7'h50;
  localparam logic [6:0] RCG_DIG_DIV_LOW = 7'h1e;
  localparam logic [6:0] RCG_DIG_DIV_HIGH = 7'h28;
  localparam logic [6:0] RCG_IF_DIV_LOW = 7'h09;
  localparam logic [6:0] RCG_IF_DIV_HIGH = 7'h0c;

  // Data manager half-bit lengths per rate range
  localparam int RCG_CLK_HZ = 25000000;
  localparam int RCG_RATE0_BPS = 4800;
  localparam int RCG_RATE1_BPS = 9600;
  localparam int RCG_RATE2_BPS = 14400;
  localparam int RCG_RATE3_BPS = 19200;
  localparam logic [11:0] RCG_HB0_CYC = 12'(RCG_CLK_HZ / (2 * RCG_RATE0_BPS));
  localparam logic [11:0] RCG_HB1_CYC = 12'(RCG_CLK_HZ / (2 * RCG_RATE1_BPS));
  localparam logic [11:0] RCG_HB2_CYC = 12'(RCG_CLK_HZ / (2 * RCG_RATE2_BPS));
  localparam logic [11:0] RCG_HB3_CYC = 12'(RCG_CLK_HZ / (2 * RCG_RATE3_BPS));

  // Receiver on-time after a timed wakeup, in state-machine clock ticks
  localparam logic [11:0] RCG_RX_ON_TICKS = 12'h040;

  // ----------------------------------------------------------------
  // Control states and synthesizer words
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RCG_ST_CONFIG = 2'h0,
    RCG_ST_STANDBY = 2'h1,
    RCG_ST_RECEIVE = 2'h3,
    RCG_ST_LVDMON = 2'h2
  } rcg_state_t;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] ctr;
    logic [15:0] hi;
  } rcg_synth_t;

endpackage : rcg_pkg

// *** core/rcg_top.sv ***
// Receiver clock generation, supply monitor and receive-chain control
//
// Contract
// - Power-on reset restores every register value
// - Supply monitor runs only while enabled
// - Low supply sets flag; status read clears
// - Monitor enabled keeps device out of standby
// - Band select codes pair bands, LO bits
// - Clock dividers 60/30 low band, else 80/40
// - IF divider 9 or 12 by band bit
// - Drop received data while synthesizer unlocked
// - Data manager recovers clock, decodes Manchester
// - Without data manager, pass sliced data
// - Config picks data rate and filter bandwidth
// - Two configurations, switched on timed wakeup or command
// - Strobe oscillator times periodic receiver wakeups
// - Four selectable LNA gain steps
// - Friendly access derives synthesizer words internally
// - Control machine steps on state-machine clock
// - After reset start in standby
// - Config select low forces configuration immediately
`timescale 1ns/1ps

module rcg_top
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire rcg_pkg::rcg_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // Pins and analog status
  input wire logic config_select_n,
  input wire logic strobe_in,
  input wire logic supply_low,
  input wire logic pll_unlock,
  input wire logic sliced_data,
  // Derived clocks
  output logic data_output_clock,
  output logic dig_clock,
  output logic if_ref_clock,
  // Receive data path
  output logic rx_data,
  output logic rx_clock,
  // Receive chain control
  output rcg_pkg::rcg_state_t fsm_state,
  output logic monitor_on,
  output logic [1:0] lna_gain,
  output logic [1:0] lpf_bw_sel,
  output logic [1:0] rate_sel,
  output rcg_pkg::rcg_synth_t synth
);
  import rcg_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic sliced_prev_q;
  wire [4:0] pins_raw = {config_select_n, strobe_in, supply_low, pll_unlock, sliced_data};
  wire cfg_n_s = sync2_q[4];
  wire strobe_s = sync2_q[3];
  wire supply_low_s = sync2_q[2];
  wire unlock_s = sync2_q[1];
  wire sliced_s = sync2_q[0];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync1_q <= RCG_RST_SYNC;
      sync2_q <= RCG_RST_SYNC;
      sliced_prev_q <= 1'b0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sliced_prev_q <= sliced_s;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] regs_q [RCG_NREGS];
  logic [7:0] rd_data_q;
  logic lvd_flag_q;
  logic bank_q;
  rcg_state_t state_q;
  rcg_state_t state_d;

  wire addr_ok = bus_req.addr < 4'(RCG_NREGS);
  wire store_we = bus_req.we && addr_ok;
  wire switch_cmd = bus_req.we && (bus_req.addr == RCG_OFS_SWITCH) && bus_req.wdata[0];
  wire status_rd = bus_req.re && (bus_req.addr == RCG_OFS_STATUS);
  wire [7:0] ctrl_w = regs_q[RCG_OFS_CTRL];
  wire lvd_en = ctrl_w[RCG_CTRL_LVD_EN];
  wire dm_en = ctrl_w[RCG_CTRL_DM_EN];
  wire sosc_en = ctrl_w[RCG_CTRL_SOSC_EN];
  wire auto_sw = ctrl_w[RCG_CTRL_AUTO_SW];
  wire friendly = ctrl_w[RCG_CTRL_FRIENDLY];
  wire rx_en = ctrl_w[RCG_CTRL_RX_EN];
  wire [7:0] status_w = {3'h0, unlock_s, state_q, bank_q, lvd_flag_q};
  wire [7:0] rd_mux = (bus_req.addr == RCG_OFS_STATUS) ? status_w :
                      addr_ok ? regs_q[bus_req.addr] : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      for (int i = 0; i < RCG_NREGS; i++) begin
        regs_q[i] <= RCG_RST_REG;
      end
      rd_data_q <= 8'h00;
    end else begin
      if (store_we) begin
        regs_q[bus_req.addr] <= bus_req.wdata;
      end
      rd_data_q <= bus_req.re ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Supply monitor
  // ----------------------------------------------------------------
  // The comparator output is only trusted while the monitor is powered.
  wire lvd_event = lvd_en && supply_low_s;
  wire lvd_flag_d = lvd_event ? 1'b1 : (status_rd ? 1'b0 : lvd_flag_q);
  logic monitor_on_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lvd_flag_q <= 1'b0;
      monitor_on_q <= 1'b0;
    end else begin
      lvd_flag_q <= lvd_flag_d;
      monitor_on_q <= lvd_en;
    end
  end

  // ----------------------------------------------------------------
  // Active configuration bank
  // ----------------------------------------------------------------
  rcg_cfg_t cfg_w;
  assign cfg_w = bank_q ? rcg_cfg_t'(regs_q[RCG_OFS_CFG_B]) : rcg_cfg_t'(regs_q[RCG_OFS_CFG_A]);
  wire low_band = (cfg_w.band_select == RCG_BAND_300);

  // ----------------------------------------------------------------
  // Clock dividers: data output, state machine, IF reference
  // ----------------------------------------------------------------
  logic [6:0] div_n [3];
  logic [6:0] div_cnt_q [3];
  logic [2:0] div_out_q;
  logic [2:0] div_tick;
  assign div_n[0] = low_band ? RCG_DOUT_DIV_LOW : RCG_DOUT_DIV_HIGH;
  assign div_n[1] = low_band ? RCG_DIG_DIV_LOW : RCG_DIG_DIV_HIGH;
  assign div_n[2] = cfg_w.band_select[0] ? RCG_IF_DIV_HIGH : RCG_IF_DIV_LOW;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_div
      // Wrapping on >= keeps a ratio change from running the counter away.
      wire wrap = div_cnt_q[gi] >= (div_n[gi] - 7'h01);
      wire [6:0] cnt_d = wrap ? 7'h00 : (div_cnt_q[gi] + 7'h01);
      assign div_tick[gi] = wrap;
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          div_cnt_q[gi] <= 7'h00;
          div_out_q[gi] <= 1'b0;
        end else begin
          div_cnt_q[gi] <= cnt_d;
          div_out_q[gi] <= cnt_d < {1'b0, div_n[gi][6:1]};
        end
      end
    end
  endgenerate

  wire dig_tick = div_tick[1];

  // ----------------------------------------------------------------
  // Strobe oscillator wakeup timer
  // ----------------------------------------------------------------
  logic [11:0] wake_cnt_q;
  logic [11:0] on_cnt_q;
  wire idle_st = (state_q == RCG_ST_STANDBY) || (state_q == RCG_ST_LVDMON);
  wire [11:0] wake_period = {regs_q[RCG_OFS_WAKE], 4'h0};
  wire wake_run = idle_st && sosc_en && rx_en && cfg_n_s && (wake_period != 12'h000);
  wire wake_hit = wake_run && dig_tick && (wake_cnt_q >= wake_period);
  wire [11:0] wake_cnt_d = !wake_run ? RCG_RST_CNT :
                           wake_hit ? RCG_RST_CNT :
                           dig_tick ? (wake_cnt_q + 12'h001) : wake_cnt_q;
  wire [11:0] on_cnt_d = wake_hit ? RCG_RX_ON_TICKS :
                         (dig_tick && (on_cnt_q != 12'h000)) ? (on_cnt_q - 12'h001) : on_cnt_q;
  wire bank_d = (switch_cmd || (wake_hit && auto_sw)) ? !bank_q : bank_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wake_cnt_q <= RCG_RST_CNT;
      on_cnt_q <= RCG_RST_CNT;
      bank_q <= 1'b0;
    end else begin
      wake_cnt_q <= wake_cnt_d;
      on_cnt_q <= on_cnt_d;
      bank_q <= bank_d;
    end
  end

  // ----------------------------------------------------------------
  // Control state machine
  // ----------------------------------------------------------------
  wire rcg_state_t idle_target = lvd_en ? RCG_ST_LVDMON : RCG_ST_STANDBY;
  wire wake_req = rx_en && (strobe_s || wake_hit);

  always_comb begin
    state_d = state_q;
    if (!cfg_n_s) begin
      state_d = RCG_ST_CONFIG;
    end else if (dig_tick) begin
      unique case (state_q)
        RCG_ST_CONFIG: state_d = wake_req ? RCG_ST_RECEIVE : idle_target;
        RCG_ST_STANDBY: state_d = wake_req ? RCG_ST_RECEIVE : idle_target;
        RCG_ST_LVDMON: state_d = wake_req ? RCG_ST_RECEIVE : idle_target;
        RCG_ST_RECEIVE: begin
          if (!rx_en || (!strobe_s && (on_cnt_q == 12'h000))) begin
            state_d = idle_target;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= RCG_ST_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Receive data path and Manchester data manager
  // ----------------------------------------------------------------
  wire rx_on = (state_q == RCG_ST_RECEIVE);
  wire dm_run = rx_on && dm_en && !unlock_s;
  wire [11:0] hb_len = (cfg_w.rate == 2'h0) ? RCG_HB0_CYC :
                       (cfg_w.rate == 2'h1) ? RCG_HB1_CYC :
                       (cfg_w.rate == 2'h2) ? RCG_HB2_CYC : RCG_HB3_CYC;
  wire [11:0] hb_mid = {1'b0, hb_len[11:1]};
  logic [11:0] ph_cnt_q;
  logic half_q;
  logic first_q;
  logic rx_data_q;
  logic rx_clock_q;
  // Every line edge sits on a half-bit boundary, so each one realigns the phase.
  wire line_edge = sliced_s ^ sliced_prev_q;
  wire ph_wrap = ph_cnt_q >= (hb_len - 12'h001);
  wire [11:0] ph_cnt_d = (!dm_run || line_edge || ph_wrap) ? RCG_RST_CNT : (ph_cnt_q + 12'h001);
  wire mid_hit = dm_run && (ph_cnt_q == hb_mid);
  // A missing mid-bit transition means the pairing slipped; slide by one half.
  wire bit_done = mid_hit && half_q && (sliced_s != first_q);
  wire half_d = !dm_run ? 1'b0 : (mid_hit ? !bit_done : half_q);
  wire first_d = (mid_hit && !bit_done) ? sliced_s : first_q;
  wire rx_data_d = (!rx_on || unlock_s) ? 1'b0 :
                   dm_en ? (bit_done ? first_q : rx_data_q) : sliced_s;
  wire rx_clock_d = !dm_run ? 1'b0 : (bit_done ? 1'b1 : (mid_hit ? 1'b0 : rx_clock_q));

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ph_cnt_q <= RCG_RST_CNT;
      half_q <= 1'b0;
      first_q <= 1'b0;
      rx_data_q <= 1'b0;
      rx_clock_q <= 1'b0;
    end else begin
      ph_cnt_q <= ph_cnt_d;
      half_q <= half_d;
      first_q <= first_d;
      rx_data_q <= rx_data_d;
      rx_clock_q <= rx_clock_d;
    end
  end

  // ----------------------------------------------------------------
  // Synthesizer words and chain settings
  // ----------------------------------------------------------------
  wire [15:0] carrier = {regs_q[RCG_OFS_CAR_H], regs_q[RCG_OFS_CAR_L]};
  wire [15:0] deviation = {8'h00, regs_q[RCG_OFS_DEV]};
  rcg_synth_t synth_d;
  rcg_synth_t synth_q;
  logic [1:0] lna_gain_q;
  logic [1:0] lpf_bw_q;
  logic [1:0] rate_q;
  // Direct access trusts the host to have written all three word pairs.
  assign synth_d = friendly ?
    {carrier - deviation, carrier, carrier + deviation} :
    {regs_q[RCG_OFS_DLO_H], regs_q[RCG_OFS_DLO_L], regs_q[RCG_OFS_DCT_H],
     regs_q[RCG_OFS_DCT_L], regs_q[RCG_OFS_DHI_H], regs_q[RCG_OFS_DHI_L]};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      synth_q <= '0;
      lna_gain_q <= 2'h0;
      lpf_bw_q <= 2'h0;
      rate_q <= 2'h0;
    end else begin
      synth_q <= synth_d;
      lna_gain_q <= ctrl_w[RCG_CTRL_LNA_LSB +: 2];
      lpf_bw_q <= cfg_w.lpf_bw;
      rate_q <= cfg_w.rate;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data = rd_data_q;
  assign data_output_clock = div_out_q[0];
  assign dig_clock = div_out_q[1];
  assign if_ref_clock = div_out_q[2];
  assign rx_data = rx_data_q;
  assign rx_clock = rx_clock_q;
  assign fsm_state = state_q;
  assign monitor_on = monitor_on_q;
  assign lna_gain = lna_gain_q;
  assign lpf_bw_sel = lpf_bw_q;
  assign rate_sel = rate_q;
  assign synth = synth_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_cfg_forced: assert property (!cfg_n_s |=> state_q == RCG_ST_CONFIG)
    else $error("config select low did not force configuration");
  a_lvd_flag_set: assert property (lvd_en && supply_low_s |=> lvd_flag_q)
    else $error("low supply event lost");
  a_lvd_read_clear: assert property (status_rd && !lvd_event ##1 1'b1 |-> !lvd_flag_q)
    else $error("status read did not clear supply flag");
  a_lvd_gated: assert property (!lvd_en && !lvd_flag_q |=> !lvd_flag_q)
    else $error("supply flag set while monitor disabled");
  a_no_standby: assert property (dig_tick && cfg_n_s && lvd_en |=> state_q != RCG_ST_STANDBY)
    else $error("standby entered with monitor enabled");
  a_dout_low_wrap: assert property (low_band && div_cnt_q[0] == 7'h3b |=> div_cnt_q[0] == 7'h00)
    else $error("data clock divider wrong in low band");
  a_dout_high_run: assert property (!low_band && $stable(cfg_w) && div_cnt_q[0] == 7'h3b
    |=> div_cnt_q[0] == 7'h3c)
    else $error("data clock divider wrapped early in high band");
  a_if_div_wrap: assert property (!cfg_w.band_select[0] && div_cnt_q[2] == 7'h08
    |=> div_cnt_q[2] == 7'h00)
    else $error("IF divider not dividing by nine");
  a_unlock_drop: assert property (unlock_s |=> !rx_data_q && !rx_clock_q)
    else $error("data passed while synthesizer unlocked");
  a_raw_pass: assert property (rx_on && !dm_en && !unlock_s |=> rx_data_q == $past(sliced_s))
    else $error("sliced data not passed through");
  a_bank_switch: assert property (switch_cmd |=> bank_q != $past(bank_q))
    else $error("bank switch command ignored");
  a_wake_rx: assert property (wake_hit && cfg_n_s |=> state_q == RCG_ST_RECEIVE ##1
    on_cnt_q <= RCG_RX_ON_TICKS)
    else $error("timed wakeup did not start reception");

  c_receive: cover property (idle_st ##1 rx_on);
  c_lvd_flag: cover property (lvd_event ##1 status_rd);
  c_auto_switch: cover property (wake_hit && auto_sw);
  logic [11:0] bit_gap_q;
  wire [11:0] bit_gap_d = bit_done ? 12'h000 : bit_gap_q + {11'h000, bit_gap_q != 12'hfff};
  always_ff @(posedge clk_sys) begin
    bit_gap_q <= !reset_n ? 12'hfff : bit_gap_d;
  end
  c_bit_decoded: cover property (bit_done && bit_gap_q < 12'h7d0);

endmodule : rcg_top

// *** bench/rcg_host.sv ***
// Host controller model: register-port master that notes each expected read
`timescale 1ns/1ps

module rcg_host (
  // Clock
  input wire logic clk_sys,
  // Register port
  output rcg_pkg::rcg_bus_req_t bus_req
);
  import rcg_pkg::*;

  logic [7:0] exp_q[$];

  initial bus_req = '0;

  // Each access ends on an idle edge, so two calls never drive one time step twice
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
  endtask : rd

  // Direct access: the host itself writes all three synthesizer words
  task automatic wr_direct(input logic [47:0] w);
    for (int i = 0; i < 6; i++) begin
      wr(4'(RCG_OFS_DLO_H + i), w[47 - 8 * i -: 8]);
    end
  endtask : wr_direct

endmodule : rcg_host

// *** bench/rcg_top_tb.sv ***
// Self-checking bench for the receiver clock and supply control block
`timescale 1ns/1ps

module rcg_top_tb;
  import rcg_pkg::*;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic config_select_n = 1'b1;
  logic strobe_in = 1'b0;
  logic supply_low = 1'b0;
  logic pll_unlock = 1'b0;
  logic sliced_data = 1'b0;
  rcg_bus_req_t bus_req;
  logic [7:0] rd_data;
  logic data_output_clock, dig_clock, if_ref_clock, rx_data, rx_clock, monitor_on;
  logic [1:0] lna_gain, lpf_bw_sel, rate_sel;
  rcg_state_t fsm_state;
  rcg_synth_t synth;
  int miscompares = 0;
  int n_checks = 0;
  logic rd_pend = 1'b0;
  wire [2:0] clks = {if_ref_clock, dig_clock, data_output_clock};

  always #20 clk_sys = ~clk_sys;

  rcg_host u_host (.clk_sys(clk_sys), .bus_req(bus_req));

  rcg_top DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req), .rd_data(rd_data),
    .config_select_n(config_select_n), .strobe_in(strobe_in), .supply_low(supply_low),
    .pll_unlock(pll_unlock), .sliced_data(sliced_data),
    .data_output_clock(data_output_clock), .dig_clock(dig_clock),
    .if_ref_clock(if_ref_clock), .rx_data(rx_data), .rx_clock(rx_clock),
    .fsm_state(fsm_state), .monitor_on(monitor_on), .lna_gain(lna_gain),
    .lpf_bw_sel(lpf_bw_sel), .rate_sel(rate_sel), .synth(synth)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, s, e);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_pend) begin
      chk(48'(rd_data), 48'(u_host.exp_q.pop_front()));
    end
    rd_pend <= bus_req.re;
  end

  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Cycles from one rising edge of a derived clock to the next
  task automatic per_of(input int i, output int n);
    n = 0;
    @(negedge clk_sys);
    while (clks[i] === 1'b1) @(negedge clk_sys);
    while (clks[i] !== 1'b1) @(negedge clk_sys);
    while (clks[i] === 1'b1) begin
      @(negedge clk_sys);
      n++;
    end
    while (clks[i] !== 1'b1) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : per_of

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin : main
    logic [15:0] car;
    logic [7:0] dev;
    logic [47:0] w;
    int n;
    logic mbit;
    n = $urandom(32'ha2d43a3e);
    cyc(3);
    reset_n <= 1'b1;
    cyc(1);
    chk(48'(fsm_state), 48'(RCG_ST_STANDBY));
    u_host.rd(RCG_OFS_CTRL, 8'h00);
    u_host.rd(RCG_OFS_STATUS, 8'h04);
    u_host.rd(4'hf, 8'h00);
    u_host.rd(RCG_OFS_SWITCH, 8'h00);
    $display("test reset done");
    for (int b = 0; b < 4; b++) begin
      u_host.wr(RCG_OFS_CFG_A, 8'(b));
      cyc(100);
      per_of(0, n);
      chk(48'(n), 48'(b == 0 ? 60 : 80));
      per_of(1, n);
      chk(48'(n), 48'(b == 0 ? 30 : 40));
      per_of(2, n);
      chk(48'(n), 48'(b % 2 == 1 ? 12 : 9));
      @(posedge clk_sys);
    end
    $display("test dividers done");
    for (int g = 0; g < 4; g++) begin
      u_host.wr(RCG_OFS_CTRL, 8'(g << 6));
      u_host.wr(RCG_OFS_CFG_A, {2'(g), 2'(3 - g), 4'h0});
      cyc(3);
      chk(48'(lna_gain), 48'(g));
      chk(48'({lpf_bw_sel, rate_sel}), 48'({2'(g), 2'(3 - g)}));
    end
    u_host.wr(RCG_OFS_CFG_B, 8'hd3);
    u_host.wr(RCG_OFS_SWITCH, 8'h01);
    cyc(3);
    chk(48'({lpf_bw_sel, rate_sel}), 48'(4'hd));
    u_host.rd(RCG_OFS_STATUS, 8'h06);
    u_host.wr(RCG_OFS_SWITCH, 8'h01);
    $display("test gain and banks done");
    car = 16'($urandom);
    dev = 8'($urandom);
    u_host.wr(RCG_OFS_CAR_H, car[15:8]);
    u_host.wr(RCG_OFS_CAR_L, car[7:0]);
    u_host.wr(RCG_OFS_DEV, dev);
    u_host.wr(RCG_OFS_CTRL, 8'h10);
    cyc(3);
    chk(synth, {car - 16'(dev), car, car + 16'(dev)});
    w = 48'({$urandom, $urandom});
    u_host.wr(RCG_OFS_CTRL, 8'h00);
    u_host.wr_direct(w);
    cyc(3);
    chk(synth, w);
    $display("test synth done");
    config_select_n <= 1'b0;
    cyc(4);
    chk(48'(fsm_state), 48'(RCG_ST_CONFIG));
    config_select_n <= 1'b1;
    cyc(100);
    chk(48'(fsm_state), 48'(RCG_ST_STANDBY));
    $display("test config select done");
    supply_low <= 1'b1;
    cyc(10);
    supply_low <= 1'b0;
    cyc(5);
    u_host.rd(RCG_OFS_STATUS, 8'h04);
    u_host.wr(RCG_OFS_CTRL, 8'h01);
    cyc(100);
    chk(48'({monitor_on, fsm_state}), 48'({1'b1, RCG_ST_LVDMON}));
    supply_low <= 1'b1;
    cyc(5);
    supply_low <= 1'b0;
    cyc(5);
    u_host.rd(RCG_OFS_STATUS, 8'h09);
    u_host.rd(RCG_OFS_STATUS, 8'h08);
    supply_low <= 1'b1;
    cyc(5);
    u_host.rd(RCG_OFS_STATUS, 8'h09);
    u_host.rd(RCG_OFS_STATUS, 8'h09);
    supply_low <= 1'b0;
    cyc(5);
    u_host.rd(RCG_OFS_STATUS, 8'h09);
    u_host.rd(RCG_OFS_STATUS, 8'h08);
    u_host.wr(RCG_OFS_CTRL, 8'h00);
    cyc(100);
    chk(48'(fsm_state), 48'(RCG_ST_STANDBY));
    $display("test supply monitor done");
    u_host.wr(RCG_OFS_CTRL, 8'h20);
    strobe_in <= 1'b1;
    cyc(100);
    chk(48'(fsm_state), 48'(RCG_ST_RECEIVE));
    for (int i = 0; i < 8; i++) begin
      sliced_data <= 1'($urandom);
      cyc(6);
      chk(48'(rx_data), 48'(sliced_data));
    end
    pll_unlock <= 1'b1;
    sliced_data <= 1'b1;
    cyc(6);
    chk(48'(rx_data), 48'h0);
    u_host.rd(RCG_OFS_STATUS, 8'h1c);
    pll_unlock <= 1'b0;
    $display("test receive done");
    reset_n <= 1'b0;
    strobe_in <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(1);
    chk(48'(fsm_state), 48'(RCG_ST_STANDBY));
    u_host.rd(RCG_OFS_CTRL, 8'h00);
    u_host.rd(RCG_OFS_CFG_B, 8'h00);
    cyc(2);
    $display("test second reset done");
    u_host.wr(RCG_OFS_CFG_A, 8'h30);
    u_host.wr(RCG_OFS_CTRL, 8'h22);
    strobe_in <= 1'b1;
    cyc(1400);
    // The first bit opens at the idle high level so the half pairing settles on it
    for (int i = 0; i < 6; i++) begin
      mbit = (i == 0) ? 1'b1 : 1'($urandom);
      sliced_data <= mbit;
      cyc(int'(RCG_HB3_CYC));
      sliced_data <= !mbit;
      cyc(int'(RCG_HB3_CYC));
      chk(48'({rx_clock, rx_data}), 48'({1'b1, mbit}));
    end
    $display("test data manager done");
    strobe_in <= 1'b0;
    u_host.wr(RCG_OFS_WAKE, 8'h01);
    u_host.wr(RCG_OFS_CTRL, 8'h2c);
    cyc(600);
    u_host.rd(RCG_OFS_STATUS, 8'h0e);
    $display("test timed wakeup done");
    end_of_test();
  end

endmodule : rcg_top_tb
